//--- rtl/pca_defs.svh
// Register offsets, field positions, reset values and divider counts of the counter array.
// Assumes a 32-bit classic Wishbone slave with byte addresses and data in the low byte.
`ifndef PCA_DEFS_SVH
`define PCA_DEFS_SVH

// Word-aligned byte offsets of the shared registers.
`define CTRL_OFS 8'h00
`define AMODE_OFS 8'h04
`define CNTL_OFS 8'h08
`define CNTH_OFS 8'h0C
// Module n occupies MOD_BASE + n * MOD_STRIDE: mode, then low byte, then high byte.
`define MOD_BASE 8'h20
`define MOD_STRIDE 8'h10
`define MOD_MODE_SUB 8'h00
`define MOD_LOW_SUB 8'h04
`define MOD_HIGH_SUB 8'h08

// Fields of array_control_reg.
`define CTRL_CF_BIT 7
`define CTRL_CR_BIT 6
`define CTRL_WDFLAG_BIT 4

// Fields of array_mode_reg.
`define AMODE_IDLE_SUSPEND_BIT_BIT 7
`define AMODE_WATCHDOG_ENABLE_BIT_BIT 6
`define AMODE_WATCHDOG_LOCK_BIT_BIT 5
`define AMODE_CPS_HI 3
`define AMODE_CPS_LO 1
`define AMODE_ECF_BIT 0

// Reset and forced values.
`define AMODE_RESET 8'h40
`define WDT_FORCED_MODE 8'h48
`define MODULE_COUNT 5
`define WDT_MODULE 4

// Clock source encodings and divider lengths.
`define CPS_DIV12 3'h0
`define CPS_DIV4 3'h1
`define CPS_EXT 3'h3
`define CPS_SYSCLK 3'h4
`define DIV12_LAST 4'hB
`define DIV4_LAST 4'h3

`endif

//--- rtl/pca_pkg.sv
// Types shared by the counter array top and the bench: bus carriers and the module mode layout.
// Assumes a 32-bit classic Wishbone bus with an 8-bit byte address.
package pca_pkg;

  // Master to slave signals of one classic Wishbone access.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  // Slave to master answer.
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // Layout of module_mode_reg, most significant bit first.
  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable_bit;
    logic capture_pos;
    logic capture_neg;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_enable_bit;
    logic flag_interrupt_enable;
  } mode_s;

endpackage : pca_pkg

//--- rtl/pca_prescaler.sv
// Array clock enable generator: turns the clock source selection into a one-cycle tick.
// Assumes ext_tick_i is already synchronous to clk_i and one cycle wide per external edge.
`timescale 1ns/1ps
`include "pca_defs.svh"

module pca_prescaler (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Source selection and external event.
  input wire logic [2:0] source_i,
  input wire logic ext_tick_i,
  // Array clock enable.
  output logic tick_o
);

  logic [3:0] div_ff;
  logic [3:0] last;

  // Divider length for the two divided sources; unknown codes fall back to the slowest divider.
  always_comb begin
    last = (source_i == `CPS_DIV4) ? `DIV4_LAST : `DIV12_LAST;
  end

  // Free-running divider; a source change simply restarts at the next wrap.
  always_ff @(posedge clk_i) begin
    if (rst_i || div_ff >= last) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // Tick is combinational so the counter steps in the same cycle the divider wraps.
  always_comb begin
    case (source_i)
      `CPS_SYSCLK: tick_o = 1'b1;
      `CPS_EXT: tick_o = ext_tick_i;
      default: tick_o = (div_ff == last);
    endcase
  end

endmodule : pca_prescaler

//--- rtl/pca_wdt_pwm16.sv
// Counter array with five compare modules (16-bit PWM and software timer) and the module 4 watchdog.
// Assumes a classic Wishbone master on one 20 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "pca_defs.svh"

module pca_wdt_pwm16 (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire pca_pkg::wb_req_s wb_req_i,
  output pca_pkg::wb_rsp_s wb_rsp_o,
  // System inputs.
  input wire logic cpu_idle_i,
  input wire logic ext_tick_i,
  // Outputs.
  output logic [4:0] module_output_pin_o,
  output logic wdt_reset_o
);

  // Byte address of register sub of module n.
  function automatic logic [7:0] mod_adr(input int n, input logic [7:0] sub);
    mod_adr = `MOD_BASE + 8'(n) * `MOD_STRIDE + sub;
  endfunction : mod_adr

  // Mode seen by the compare logic; module 4 is pinned to software timer while guarding.
  function automatic pca_pkg::mode_s eff_mode(input int n, input pca_pkg::mode_s m, input logic wd);
    eff_mode = (n == `WDT_MODULE && wd) ? pca_pkg::mode_s'(`WDT_FORCED_MODE) : m;
  endfunction : eff_mode

  // Bus state: acknowledge and the read word captured for it.
  logic ack_ff;
  logic [31:0] rdat_ff;

  // Control register: overflow flag, run bit and the five module event flags.
  logic cf_ff;
  logic cr_ff;
  logic [4:0] flag_ff;

  // Mode register fields; lock only ever sets until the next reset.
  logic idle_suspend_bit_ff;
  logic watchdog_enable_bit_ff;
  logic watchdog_lock_bit_ff;
  logic ecf_ff;
  logic [2:0] cps_ff;

  // The 16-bit counter and the five compare modules.
  logic [15:0] cnt_ff;
  pca_pkg::mode_s mode_ff [`MODULE_COUNT];
  logic [7:0] cpl_ff [`MODULE_COUNT];
  logic [7:0] cph_ff [`MODULE_COUNT];

  // Registered outputs.
  logic [4:0] out_ff;
  logic wdt_rst_ff;

  // Bus decode.
  logic req;
  logic wr;
  logic [7:0] wdata;
  logic wr_ctrl;
  logic wr_amode;
  logic wr_cntl;
  logic wr_cnth;

  // Counting and compare.
  logic wdt_en;
  logic tick;
  logic step;
  logic [15:0] nxt_cnt;
  logic ovf;
  logic low_ovf;
  logic [4:0] match;
  logic [4:0] pwm16_on;
  logic [4:0] flag_set;
  logic [31:0] nxt_rdat;
  logic wd_hit;
  logic wd_force;

  // Reset image of the mode register, sliced field by field below.
  localparam logic [7:0] amode_init = `AMODE_RESET;

  // Bus qualification: a write lands on the edge where ack is high, so only once per access.
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign wr = req & wb_req_i.we & ack_ff & wb_req_i.sel[0];
  assign wdata = wb_req_i.dat[7:0];
  assign wb_rsp_o = '{ack: ack_ff, dat: rdat_ff};

  // Accepted writes to the shared registers, decoded once for every process that needs them.
  assign wr_ctrl = wr & (wb_req_i.adr == `CTRL_OFS);
  assign wr_amode = wr & (wb_req_i.adr == `AMODE_OFS);
  assign wr_cntl = wr & (wb_req_i.adr == `CNTL_OFS);
  assign wr_cnth = wr & (wb_req_i.adr == `CNTH_OFS);

  // Enable and lock each keep the watchdog on.
  assign wdt_en = watchdog_enable_bit_ff | watchdog_lock_bit_ff;

  // Array clock enable from the selected source; defaults to divide by 12.
  // A change to a divided source takes effect at the next divider wrap, so one period may come out short.
  pca_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .source_i(cps_ff),
    .ext_tick_i(ext_tick_i),
    .tick_o(tick)
  );

  // The guard forces counting regardless of the run bit; idle suspend still applies.
  // Idle pauses the array only when the idle suspend bit is set and the CPU reports idle.
  assign step = tick & (cr_ff | wdt_en) & ~(idle_suspend_bit_ff & cpu_idle_i);
  assign nxt_cnt = cnt_ff + 16'h0001;
  assign ovf = step & (cnt_ff == 16'hFFFF);
  assign low_ovf = step & (cnt_ff[7:0] == 8'hFF);

  // Matches are taken as the counter steps onto the compare word, so the output rises with it.
  always_comb begin
    pca_pkg::mode_s m;
    m = '0;
    for (int n = 0; n < `MODULE_COUNT; n++) begin
      m = eff_mode(n, mode_ff[n], wdt_en);
      match[n] = step & m.compare_enable_bit & (nxt_cnt == {cph_ff[n], cpl_ff[n]});
      pwm16_on[n] = m.compare_enable_bit & m.pwm_enable_bit & m.wide_pwm_select;
      flag_set[n] = match[n] & m.match_flag_enable;
    end
  end

  // Watchdog trip sources. The deadline falls where the low byte wraps with the high bytes equal,
  // so an update late in a low-byte period still buys a full period per offset step.
  assign wd_hit = wdt_en & low_ovf & (cph_ff[`WDT_MODULE] == cnt_ff[15:8]);
  assign wd_force = wdt_en & wr_ctrl & wdata[`CTRL_WDFLAG_BIT];

  // Classic single-cycle acknowledge: one wait state, dropped the cycle after it is given.
  // A master that keeps the request up after ack simply starts a second access.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read multiplexer; unmapped addresses answer zero.
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (wb_req_i.adr)
      `CTRL_OFS: nxt_rdat = {24'h000000, cf_ff, cr_ff, 1'b0, flag_ff};
      `AMODE_OFS: nxt_rdat = {24'h000000, idle_suspend_bit_ff, watchdog_enable_bit_ff, watchdog_lock_bit_ff, 1'b0, cps_ff, ecf_ff};
      `CNTL_OFS: nxt_rdat = {24'h000000, cnt_ff[7:0]};
      `CNTH_OFS: nxt_rdat = {24'h000000, cnt_ff[15:8]};
      default: begin
        // Module 4 mode reads as the forced software timer while guarding.
        for (int n = 0; n < `MODULE_COUNT; n++) begin
          if (wb_req_i.adr == mod_adr(n, `MOD_MODE_SUB)) begin
            nxt_rdat = {24'h000000, eff_mode(n, mode_ff[n], wdt_en)};
          end
          if (wb_req_i.adr == mod_adr(n, `MOD_LOW_SUB)) begin
            nxt_rdat = {24'h000000, cpl_ff[n]};
          end
          if (wb_req_i.adr == mod_adr(n, `MOD_HIGH_SUB)) begin
            nxt_rdat = {24'h000000, cph_ff[n]};
          end
        end
      end
    endcase
  end

  // Read data is captured as ack rises and held while ack stands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  // Overflow flag: sticky, and an overflow in the same cycle beats a clearing write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cf_ff <= 1'b0;
    end else if (wr_ctrl) begin
      cf_ff <= wdata[`CTRL_CF_BIT] | ovf;
    end else begin
      cf_ff <= cf_ff | ovf;
    end
  end

  // Run bit holds only what software wrote, so it reads zero while the guard alone runs the counter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr_ff <= 1'b0;
    end else if (wr_ctrl) begin
      cr_ff <= wdata[`CTRL_CR_BIT];
    end
  end

  // Event flags: written value kept, a hardware match in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 5'h00;
    end else if (wr_ctrl) begin
      flag_ff <= wdata[4:0] | flag_set;
    end else begin
      flag_ff <= flag_ff | flag_set;
    end
  end

  // Guard enable and lock: enabled after any reset, and lock only ever sets until reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_enable_bit_ff <= amode_init[`AMODE_WATCHDOG_ENABLE_BIT_BIT];
      watchdog_lock_bit_ff <= amode_init[`AMODE_WATCHDOG_LOCK_BIT_BIT];
    end else if (wr_amode) begin
      watchdog_enable_bit_ff <= wdata[`AMODE_WATCHDOG_ENABLE_BIT_BIT];
      watchdog_lock_bit_ff <= watchdog_lock_bit_ff | wdata[`AMODE_WATCHDOG_LOCK_BIT_BIT];
    end
  end

  // Overflow interrupt enable is stored only; the block has no interrupt logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ecf_ff <= amode_init[`AMODE_ECF_BIT];
    end else if (wr_amode) begin
      ecf_ff <= wdata[`AMODE_ECF_BIT];
    end
  end

  // Source and idle are frozen while guarding; the old enable decides, so software must disable first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_suspend_bit_ff <= amode_init[`AMODE_IDLE_SUSPEND_BIT_BIT];
      cps_ff <= `CPS_DIV12;
    end else if (wr_amode && !wdt_en) begin
      idle_suspend_bit_ff <= wdata[`AMODE_IDLE_SUSPEND_BIT_BIT];
      cps_ff <= wdata[`AMODE_CPS_HI:`AMODE_CPS_LO];
    end
  end

  // Counter: software loads are refused while guarding; a load wins over a step.
  // Loads are byte-wise, so software should stop the counter before loading both bytes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
    end else if (wr_cntl && !wdt_en) begin
      cnt_ff[7:0] <= wdata;
    end else if (wr_cnth && !wdt_en) begin
      cnt_ff[15:8] <= wdata;
    end else if (step) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Module registers; the byte writes also steer compare enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < `MODULE_COUNT; n++) begin
        mode_ff[n] <= '0;
        cpl_ff[n] <= 8'h00;
        cph_ff[n] <= 8'h00;
      end
    end else if (wr) begin
      for (int n = 0; n < `MODULE_COUNT; n++) begin
        if (n == `WDT_MODULE && wdt_en) begin
          // Mode writes are dropped and an update reloads the deadline.
          // The low byte stays writable while guarding: it is the refresh offset.
          if (wb_req_i.adr == mod_adr(n, `MOD_LOW_SUB)) begin
            cpl_ff[n] <= wdata;
          end
          if (wb_req_i.adr == mod_adr(n, `MOD_HIGH_SUB)) begin
            cph_ff[n] <= cnt_ff[15:8] + cpl_ff[n];
          end
        end else begin
          // Module 4 offers the full set of modes again once the guard is off.
          if (wb_req_i.adr == mod_adr(n, `MOD_MODE_SUB)) begin
            mode_ff[n] <= pca_pkg::mode_s'(wdata);
          end
          if (wb_req_i.adr == mod_adr(n, `MOD_LOW_SUB)) begin
            cpl_ff[n] <= wdata;
            mode_ff[n].compare_enable_bit <= 1'b0;
          end
          if (wb_req_i.adr == mod_adr(n, `MOD_HIGH_SUB)) begin
            cph_ff[n] <= wdata;
            mode_ff[n].compare_enable_bit <= 1'b1;
          end
        end
      end
    end
  end

  // PWM outputs: match raises, overflow lowers, match wins so a zero word stays high.
  // Any mode other than 16-bit PWM, including compare enable cleared, holds the pin low.
  // Both edges need an array step, so the pin only moves on ticks or when its module leaves 16-bit PWM mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 5'h00;
    end else begin
      for (int n = 0; n < `MODULE_COUNT; n++) begin
        if (!pwm16_on[n]) begin
          out_ff[n] <= 1'b0;
        end else if (match[n]) begin
          out_ff[n] <= 1'b1;
        end else if (ovf) begin
          out_ff[n] <= 1'b0;
        end
      end
    end
  end

  // Watchdog request: both sources are single-cycle events, so the flop gives one pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_rst_ff <= 1'b0;
    end else begin
      wdt_rst_ff <= wd_hit | wd_force;
    end
  end

  // Both outputs come straight from flops, so no glitch reaches the pins or the reset logic.
  assign module_output_pin_o = out_ff;
  assign wdt_reset_o = wdt_rst_ff;

endmodule : pca_wdt_pwm16

//--- testbench/pca_wdt_pwm16_sva.sv
// Checker for the counter array top: bus handshake, watchdog reset pulse and its causes.
// Assumes it is bound to pca_wdt_pwm16 and sees only that module's ports.
`timescale 1ns/1ps
module pca_wdt_pwm16_sva (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire pca_pkg::wb_req_s wb_req_i,
  input wire pca_pkg::wb_rsp_s wb_rsp_o,
  // Outputs.
  input wire logic [4:0] module_output_pin_o,
  input wire logic wdt_reset_o
);
  logic req;
  logic wr0;
  logic wd_en_ff;
  logic lock_ff;
  // Accepted write strobes, decoded once for the shadow and the assertions.
  assign req = wb_req_i.cyc && wb_req_i.stb;
  assign wr0 = wb_rsp_o.ack && req && wb_req_i.we && wb_req_i.sel[0];
  // Shadow of the watchdog enable; the lock keeps it on, so a plain copy of bit 6 would be wrong.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_en_ff <= 1'b1;
      lock_ff <= 1'b0;
    end else if (wr0 && wb_req_i.adr == 8'h04) begin
      lock_ff <= lock_ff | wb_req_i.dat[5];
      wd_en_ff <= lock_ff | wb_req_i.dat[6] | wb_req_i.dat[5];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held too long");
  a_ack_answers: assert property (req && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered");
  a_ack_needs_req: assert property ($rose(wb_rsp_o.ack) |-> $past(req))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 8'h10 |-> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset wider than one cycle");
  a_force_trip: assert property (wr0 && wb_req_i.adr == 8'h00 && wb_req_i.dat[4] && wd_en_ff |=> ##[0:1] wdt_reset_o)
    else $error("forced watchdog reset missing");
  a_off_no_trip: assert property (!wd_en_ff |=> !wdt_reset_o)
    else $error("watchdog reset while disabled");
  c_trip: cover property (wdt_reset_o);
  c_force: cover property (wr0 && wb_req_i.adr == 8'h00 && wb_req_i.dat[4]);
  c_pin: cover property ($rose(|module_output_pin_o));
endmodule : pca_wdt_pwm16_sva

bind pca_wdt_pwm16 pca_wdt_pwm16_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .module_output_pin_o(module_output_pin_o), .wdt_reset_o(wdt_reset_o));

//--- testbench/testbench.sv
// Self-checking bench: watchdog defaults, refresh timing, forced trip, lock and 16-bit PWM.
// Assumes a one-cycle Wishbone ack and a system clock array tick for source 4.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pca_pkg::wb_req_s req = '0;
  pca_pkg::wb_rsp_s rsp;
  logic [4:0] pins;
  logic wdt_rst;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  int cyc_n = 0;
  int t0, hi_n, oth_n, m, k, l0, c;
  logic [7:0] mode;
  logic idle = 1'b0;

  pca_wdt_pwm16 dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .cpu_idle_i(idle),
    .ext_tick_i(1'b0), .module_output_pin_o(pins), .wdt_reset_o(wdt_rst));

  // Clock of 50 ns period.
  always #25 clk_i = ~clk_i;

  // Cycle count for timing checks, and the hang limit.
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Watchdog deadline in array ticks after an update with this offset and counter low byte.
  function automatic int wd_ticks(input int offset, input int low);
    return 256 * offset + 256 - low;
  endfunction : wd_ticks

  // High samples in one 16-bit PWM period when the counter starts at 0xFF00.
  function automatic int pwm_high(input int cmp);
    return 256 - cmp;
  endfunction : pwm_high

  // One classic cycle; request held until ack is sampled, then dropped for a cycle.
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rdc

  task automatic sys_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cyc_n;
    @(posedge clk_i);
  endtask : sys_reset

  // The watchdog pulse must land inside a window measured from t0.
  task automatic wait_trip(input int lo, input int hi);
    while (wdt_rst !== 1'b1) @(posedge clk_i);
    check(cyc_n - t0 >= lo && cyc_n - t0 <= hi, 32'h1);
  endtask : wait_trip

  // Main sequence; PWM runs start the counter at 0xFF00 so the high phase and the overflow fit in a few hundred cycles.
  initial begin
    void'($urandom(32'h3cfd300b));
    sys_reset();
    rdc(8'h04, 32'h40);
    rdc(8'h00, 32'h00);
    rdc(8'h60, 32'h48);
    wr(8'h60, 8'h00);
    rdc(8'h60, 32'h48);
    wr(8'h0C, 8'hAA);
    rdc(8'h0C, 32'h00);
    wr(8'h04, 8'hC8);
    rdc(8'h04, 32'h40);
    wr(8'h00, 8'h00);
    rdc(8'h10, 32'h00);
    wait_trip(12 * wd_ticks(0, 0), 12 * wd_ticks(0, 0) + 18);
    for (int i = 0; i < 2; i++) begin
      sys_reset();
      k = $urandom_range(3);
      l0 = $urandom_range(8'hC0);
      wr(8'h04, 8'h00);
      wr(8'h08, l0[7:0]);
      wr(8'h04, 8'h08);
      wr(8'h64, k[7:0]);
      wr(8'h04, 8'h48);
      t0 = cyc_n;
      wr(8'h68, 8'($urandom));
      rdc(8'h68, k);
      wait_trip(wd_ticks(k, l0) - 2, wd_ticks(k, l0) + 3);
    end
    sys_reset();
    wr(8'h00, 8'h10);
    wait_trip(0, 5);
    sys_reset();
    wr(8'h04, 8'h20);
    wr(8'h04, 8'h00);
    t0 = cyc_n;
    wr(8'h00, 8'h10);
    wait_trip(0, 5);
    // Idle suspend: configured while disabled, then frozen once the guard is back on.
    sys_reset();
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h88);
    idle <= 1'b1;
    wr(8'h04, 8'hC8);
    wr(8'h04, 8'h48);
    repeat (20) @(posedge clk_i);
    rdc(8'h08, 32'h00);
    rdc(8'h04, 32'hC8);
    idle <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdc(8'h08, 32'h0A);
    // The source can only change once the guard is off, so disable first.
    sys_reset();
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h10);
    for (int j = 0; j < 4; j++) begin
      m = $urandom_range(3);
      c = (j == 3) ? 8'hFF : $urandom_range(8'hFE, 1);
      // Match flag and its interrupt enabled except in run j == 2 (8-bit PWM, no flag); compare words change only while the counter is stopped.
      mode = (j == 2) ? 8'h42 : 8'hCB;
      wr(8'h00, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'hFF);
      wr(8'h20 + 8'(16 * m), mode);
      wr(8'h24 + 8'(16 * m), c[7:0]);
      if (j != 1) wr(8'h28 + 8'(16 * m), 8'hFF);
      wr(8'h00, 8'h40);
      hi_n = 0;
      oth_n = 0;
      repeat (300) begin
        @(posedge clk_i);
        hi_n += pins[m];
        oth_n += ((pins & ~(5'h1 << m)) != 5'h0);
      end
      check(hi_n, (j == 0 || j == 3) ? pwm_high(c) : 0);
      check(oth_n, 0);
      rdc(8'h00, (j == 0 || j == 3) ? 32'hC0 | (32'h1 << m) : 32'hC0);
      wr(8'h20 + 8'(16 * m), 8'h00);
    end
    test_done();
  end
endmodule : testbench
